// *** hw/scocp_pkg.sv ***
// Overview of operation
// R1 - Delay timer starts at detect, alert lags
// R2 - Early trip clears alert before it shows
// R3 - Short circuit alert, fault after delay
// R4 - Short circuit delay setting decode table
// R5 - Short circuit trip opens discharge switch
// R6 - Short circuit trip opens charge switch
// R7 - Recovery time counts 1 to 255 seconds
// R8 - Recovery time zero disables timed recovery
// R9 - Short circuit clears after quiet recovery time
// R10 - Within threshold alert zero, latch count clears
// R11 - Trip clears alert, sets status, counts
// R12 - Latch limit sets latched, switches held off
// R13 - Host recovery command clears short circuit
// R14 - Charge threshold is two mV times value minus one
// R15 - Charge overcurrent needs its enable bit
// R16 - Charge alert at once, fault after delay
// R17 - Charge delay piecewise decode table
// R18 - Charge trip opens charge switch
// R19 - Zero recovery time: command recovers charge fault
// R20 - Charge status clears after recovery time
// R21 - Latched charge switch never reenabled autonomously
// R22 - Sixteen short circuit threshold levels
// R23 - Short circuit needs its enable bit
// R24 - Return below threshold clears alert, timer
// R25 - Clear lapse restarts recovery timer
package scocp_pkg;

  // ==========================================================
  // Timing
  localparam int MCLK_HZ = 20_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int US_CYC = MCLK_HZ / US_PER_S;
  localparam int ALERT_LAG_US = 50;
  localparam int ALERT_LAG_CYC = ALERT_LAG_US * US_CYC;
  localparam int LATCH_CLR_S = 5;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SC_CFG = 8'h04;
  localparam logic [7:0] OFS_OCC_CFG = 8'h08;
  localparam logic [7:0] OFS_REC_CFG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;

  // ==========================================================
  // Field positions
  localparam int F_SC_EN = 0;
  localparam int F_OCC_EN = 1;
  localparam int F_DSG_M_SC = 2;
  localparam int F_CHG_M_SC = 3;
  localparam int F_CHG_M_OCC = 4;
  localparam int F_CHG_REQ = 5;
  localparam int F_DSG_REQ = 6;
  localparam int CTRL_W = 7;
  localparam int F_SC_DLY = 8;
  localparam int F_HI_BYTE = 8;
  localparam int F_REC_SC = 16;
  localparam int F_REC_OCC = 17;
  localparam logic [15:0] SUBCMD_RECOVER = 16'h009B;

  // ==========================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [3:0] SC_THR_RST = 4'h0;
  localparam logic [3:0] SC_DLY_RST = 4'h0;
  localparam logic [7:0] OCC_THR_RST = 8'h02;
  localparam logic [7:0] CHARGE_OVERCURRENT_DELAY_RST = 8'h00;
  localparam logic [7:0] REC_TIME_RST = 8'h00;
  localparam logic [7:0] LATCH_LIM_RST = 8'h00;

  // ==========================================================
  // Threshold and delay tables
  localparam logic [9:0] SC_THR_MV [16] = '{10'h00A, 10'h014, 10'h028, 10'h03C,
    10'h050, 10'h064, 10'h07D, 10'h096, 10'h0AF, 10'h0C8, 10'h0FA, 10'h12C,
    10'h15E, 10'h190, 10'h1C2, 10'h1F4};
  localparam int SC_DLY_STEP_US = 15;
  localparam logic [3:0] SC_DLY_MAX_SEL = 4'hA;
  localparam int OCC_DLY0_US = 460;
  localparam int OCC_SEG_BASE_US [4] = '{1220, 22875, 181475, 498675};
  localparam int OCC_SEG_STEP_US [4] = '{305, 2440, 4880, 9770};

endpackage

// *** hw/scocp_top.sv ***
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module scocp_top
  import scocp_pkg::*;
#(
  parameter int SEC_US = US_PER_S,
  parameter int ALERT_LAG = ALERT_LAG_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [11:0] SENSE_POS,
  input wire logic [11:0] SENSE_NEG,
  output logic CHG_SWITCH_ON,
  output logic DSG_SWITCH_ON,
  output logic CURRENT_LATCHED
);

  // ==========================================================
  // Delay decoders
  function automatic logic [12:0] sc_dly_us(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SC_DLY_MAX_SEL) ? SC_DLY_MAX_SEL : sel;
    if (s == 4'h0) begin
      return 13'h0000;
    end
    return 13'(SC_DLY_STEP_US << (s - 4'h1));
  endfunction

  function automatic logic [20:0] charge_overcurrent_delay_us(input logic [7:0] sel);
    logic [7:0] m;
    logic [1:0] seg;
    m = sel - 8'h01;
    seg = m[7:6];
    if (sel == 8'h00) begin
      return 21'(OCC_DLY0_US);
    end
    return 21'(OCC_SEG_BASE_US[seg] + OCC_SEG_STEP_US[seg] * int'(m[5:0]));
  endfunction

  // ==========================================================
  // Configuration registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [3:0] sc_thr_sel_q;
  logic [3:0] sc_dly_sel_q;
  logic [7:0] occ_thr_q;
  logic [7:0] charge_overcurrent_delay_q;
  logic [7:0] rec_time_q;
  logic [7:0] latch_lim_q;
  logic wr_ctrl;
  logic wr_sc;
  logic wr_occ;
  logic wr_rec;
  logic cmd_hit;
  logic rec_sc_cmd;
  logic rec_occ_cmd;

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign wr_sc = WR && (ADDR == OFS_SC_CFG);
  assign wr_occ = WR && (ADDR == OFS_OCC_CFG);
  assign wr_rec = WR && (ADDR == OFS_REC_CFG);
  assign cmd_hit = WR && (ADDR == OFS_CMD) && (WDATA[15:0] == SUBCMD_RECOVER);
  assign rec_sc_cmd = cmd_hit && WDATA[F_REC_SC]; // R13
  assign rec_occ_cmd = cmd_hit && WDATA[F_REC_OCC]; // R19

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      sc_thr_sel_q <= SC_THR_RST;
      sc_dly_sel_q <= SC_DLY_RST;
      occ_thr_q <= OCC_THR_RST;
      charge_overcurrent_delay_q <= CHARGE_OVERCURRENT_DELAY_RST;
      rec_time_q <= REC_TIME_RST;
      latch_lim_q <= LATCH_LIM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= WDATA[CTRL_W-1:0];
      end
      if (wr_sc) begin
        sc_thr_sel_q <= WDATA[3:0];
        sc_dly_sel_q <= WDATA[F_SC_DLY +: 4];
      end
      if (wr_occ) begin
        occ_thr_q <= WDATA[7:0];
        charge_overcurrent_delay_q <= WDATA[F_HI_BYTE +: 8];
      end
      if (wr_rec) begin
        rec_time_q <= WDATA[7:0];
        latch_lim_q <= WDATA[F_HI_BYTE +: 8];
      end
    end
  end

  // ==========================================================
  // Microsecond and second enables
  logic [4:0] us_cnt_q;
  logic [19:0] sec_cnt_q;
  logic us_tick;
  logic sec_tick;

  assign us_tick = (us_cnt_q == 5'(US_CYC - 1));
  assign sec_tick = us_tick && (sec_cnt_q == 20'(SEC_US - 1));

  always_ff @(posedge MCLK) begin
    if (RST) begin
      us_cnt_q <= 5'h00;
      sec_cnt_q <= 20'h00000;
    end else begin
      us_cnt_q <= us_tick ? 5'h00 : us_cnt_q + 5'h01;
      if (sec_tick) begin
        sec_cnt_q <= 20'h00000;
      end else if (us_tick) begin
        sec_cnt_q <= sec_cnt_q + 20'h00001;
      end
    end
  end

  // ==========================================================
  // Threshold comparison
  logic [9:0] thr_sc;
  logic [8:0] thr_occ;
  logic over_sc;
  logic over_occ;
  logic det_sc;
  logic det_occ;

  assign thr_sc = SC_THR_MV[sc_thr_sel_q]; // R22
  assign thr_occ = (occ_thr_q == 8'h00) ? 9'h000 : {occ_thr_q, 1'b0} - 9'h001; // R14
  assign over_sc = {1'b0, SENSE_NEG} > ({1'b0, SENSE_POS} + 13'(thr_sc)); // R3
  assign over_occ = {1'b0, SENSE_POS} > ({1'b0, SENSE_NEG} + 13'(thr_occ)); // R14
  assign det_sc = ctrl_q[F_SC_EN] && over_sc; // R23
  assign det_occ = ctrl_q[F_OCC_EN] && over_occ; // R15

  // ==========================================================
  // Detection delay timers
  logic [12:0] sc_us_q;
  logic [10:0] sc_lag_q;
  logic [20:0] occ_us_q;
  logic sc_st_q;
  logic occ_st_q;
  logic sc_run;
  logic occ_run;
  logic trip_sc;
  logic trip_occ;
  logic sc_lag_done;

  assign sc_run = det_sc && !sc_st_q;
  assign occ_run = det_occ && !occ_st_q;
  assign trip_sc = sc_run && (sc_us_q >= sc_dly_us(sc_dly_sel_q)); // R3 R4
  assign trip_occ = occ_run && (occ_us_q >= charge_overcurrent_delay_us(charge_overcurrent_delay_q)); // R16 R17
  assign sc_lag_done = (sc_lag_q >= 11'(ALERT_LAG));

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sc_us_q <= 13'h0000;
      sc_lag_q <= 11'h000;
      occ_us_q <= 21'h000000;
    end else begin
      if (!sc_run) begin
        sc_us_q <= 13'h0000; // R24
        sc_lag_q <= 11'h000;
      end else begin
        if (us_tick && (sc_us_q != 13'h1FFF)) begin
          sc_us_q <= sc_us_q + 13'h0001; // R1
        end
        if (!sc_lag_done) begin
          sc_lag_q <= sc_lag_q + 11'h001; // R1
        end
      end
      if (!occ_run) begin
        occ_us_q <= 21'h000000; // R24
      end else if (us_tick && (occ_us_q != 21'h1FFFFF)) begin
        occ_us_q <= occ_us_q + 21'h000001;
      end
    end
  end

  // ==========================================================
  // Alerts
  logic sc_alert_q;
  logic occ_alert_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sc_alert_q <= 1'b0;
      occ_alert_q <= 1'b0;
    end else begin
      sc_alert_q <= sc_run && !trip_sc && sc_lag_done; // R1 R2 R10 R11
      occ_alert_q <= occ_run && !trip_occ; // R16 R11
    end
  end

  // ==========================================================
  // Recovery timers and safety status
  logic [7:0] sc_rec_q;
  logic [7:0] occ_rec_q;
  logic sc_rec_done;
  logic occ_rec_done;
  logic sc_st_d;
  logic occ_st_d;

  assign sc_rec_done = sc_st_q && !over_sc && (rec_time_q != 8'h00)
    && (sc_rec_q >= rec_time_q); // R7 R8 R9
  assign occ_rec_done = occ_st_q && !over_occ && (rec_time_q != 8'h00)
    && (occ_rec_q >= rec_time_q); // R7 R8 R20
  assign sc_st_d = trip_sc || (sc_st_q && !sc_rec_done && !rec_sc_cmd); // R11 R13
  assign occ_st_d = trip_occ || (occ_st_q && !occ_rec_done && !rec_occ_cmd); // R11 R19

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sc_st_q <= 1'b0;
      occ_st_q <= 1'b0;
      sc_rec_q <= 8'h00;
      occ_rec_q <= 8'h00;
    end else begin
      sc_st_q <= sc_st_d;
      occ_st_q <= occ_st_d;
      if (!sc_st_q || over_sc) begin
        sc_rec_q <= 8'h00; // R25
      end else if (sec_tick && (sc_rec_q != 8'hFF)) begin
        sc_rec_q <= sc_rec_q + 8'h01; // R7
      end
      if (!occ_st_q || over_occ) begin
        occ_rec_q <= 8'h00; // R25
      end else if (sec_tick && (occ_rec_q != 8'hFF)) begin
        occ_rec_q <= occ_rec_q + 8'h01; // R7
      end
    end
  end

  // ==========================================================
  // Current fault latch
  logic [7:0] lat_cnt_q;
  logic [7:0] lat_cnt_d;
  logic [8:0] lat_sum;
  logic [2:0] quiet_q;
  logic quiet_done;
  logic any_fault;
  logic latched_q;
  logic latched_d;

  assign any_fault = sc_st_q || occ_st_q || trip_sc || trip_occ;
  assign quiet_done = (quiet_q == 3'(LATCH_CLR_S));
  assign lat_sum = {1'b0, lat_cnt_q} + 9'(trip_sc) + 9'(trip_occ);
  assign lat_cnt_d = (trip_sc || trip_occ) ? (lat_sum[8] ? 8'hFF : lat_sum[7:0]) // R11
    : ((quiet_done || cmd_hit) ? 8'h00 : lat_cnt_q); // R10
  assign latched_d = ((latch_lim_q != 8'h00) && (lat_cnt_d >= latch_lim_q)) // R12
    || (latched_q && !cmd_hit);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      lat_cnt_q <= 8'h00;
      quiet_q <= 3'h0;
      latched_q <= 1'b0;
    end else begin
      lat_cnt_q <= lat_cnt_d;
      latched_q <= latched_d;
      if (any_fault) begin
        quiet_q <= 3'h0;
      end else if (sec_tick && !quiet_done) begin
        quiet_q <= quiet_q + 3'h1; // R10
      end
    end
  end

  // ==========================================================
  // Switch control
  logic lat_dsg;
  logic lat_chg;
  logic dsg_on_d;
  logic chg_on_d;
  logic dsg_on_q;
  logic chg_on_q;

  assign lat_dsg = latched_d && ctrl_q[F_DSG_M_SC]; // R12
  assign lat_chg = latched_d && (ctrl_q[F_CHG_M_SC] || ctrl_q[F_CHG_M_OCC]); // R21
  assign dsg_on_d = ctrl_q[F_DSG_REQ] && !(sc_st_d && ctrl_q[F_DSG_M_SC]) // R5 R9
    && !lat_dsg;
  assign chg_on_d = ctrl_q[F_CHG_REQ] && !(sc_st_d && ctrl_q[F_CHG_M_SC]) // R6
    && !(occ_st_d && ctrl_q[F_CHG_M_OCC]) && !lat_chg; // R18 R20 R21

  always_ff @(posedge MCLK) begin
    if (RST) begin
      dsg_on_q <= 1'b0;
      chg_on_q <= 1'b0;
    end else begin
      dsg_on_q <= dsg_on_d;
      chg_on_q <= chg_on_d;
    end
  end

  assign DSG_SWITCH_ON = dsg_on_q;
  assign CHG_SWITCH_ON = chg_on_q;
  assign CURRENT_LATCHED = latched_q;

  // ==========================================================
  // Read back
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;

  assign status_word = {16'h0000, lat_cnt_q, 1'b0, dsg_on_q, chg_on_q, latched_q,
    occ_st_q, sc_st_q, occ_alert_q, sc_alert_q};
  assign rd_mux = (ADDR == OFS_CTRL) ? {25'h0000000, ctrl_q}
    : (ADDR == OFS_SC_CFG) ? {20'h00000, sc_dly_sel_q, 4'h0, sc_thr_sel_q}
    : (ADDR == OFS_OCC_CFG) ? {16'h0000, charge_overcurrent_delay_q, occ_thr_q}
    : (ADDR == OFS_REC_CFG) ? {16'h0000, latch_lim_q, rec_time_q}
    : (ADDR == OFS_STATUS) ? status_word
    : 32'h00000000;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= RD ? rd_mux : 32'h00000000;
    end
  end

  assign RDATA = rdata_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_sc_dsg_off: assert property (trip_sc && ctrl_q[F_DSG_M_SC] |=> !DSG_SWITCH_ON) // R5
    else $error("discharge switch stayed on after short circuit trip");
  a_sc_chg_off: assert property (trip_sc && ctrl_q[F_CHG_M_SC] |=> !CHG_SWITCH_ON) // R6
    else $error("charge switch stayed on after short circuit trip");
  a_occ_chg_off: assert property (trip_occ && ctrl_q[F_CHG_M_OCC] |=> !CHG_SWITCH_ON) // R18
    else $error("charge switch stayed on after charge overcurrent trip");
  a_sc_alert_lag: assert property ($rose(det_sc) && !sc_st_q |=> !sc_alert_q) // R1
    else $error("short circuit alert shown without lag");
  a_trip_clears_alert: assert property (trip_sc |=> !sc_alert_q && sc_st_q) // R2
    else $error("short circuit trip left alert or missed status");
  a_occ_alert_first: assert property (occ_run && !trip_occ |=> occ_alert_q) // R16
    else $error("charge overcurrent alert missing on detection");
  a_sc_dly_zero: assert property (sc_run && sc_dly_sel_q == 4'h0 |=> sc_st_q) // R4
    else $error("fastest short circuit delay did not trip at once");
  a_sc_disabled: assert property (!ctrl_q[F_SC_EN] && !sc_st_q |=> !sc_st_q) // R23
    else $error("disabled short circuit protection tripped");
  a_rec_zero_hold: assert property (sc_st_q && rec_time_q == 8'h00 && !rec_sc_cmd |=> sc_st_q) // R8
    else $error("short circuit status cleared with timed recovery off");
  a_rec_restart: assert property (sc_st_q && over_sc |=> sc_rec_q == 8'h00) // R25
    else $error("recovery timer not restarted");
  a_latch_count: assert property (trip_sc && !trip_occ && lat_cnt_q < 8'hFE
    |=> lat_cnt_q == $past(lat_cnt_q) + 8'h01) // R11
    else $error("latch counter not incremented on trip");
  a_latch_clear: assert property (quiet_done && !any_fault && !latched_d
    |=> lat_cnt_q == 8'h00 && !CURRENT_LATCHED) // R10
    else $error("latch counter not cleared after quiet time");
  a_latch_dsg_off: assert property (lat_dsg |=> !DSG_SWITCH_ON ##1 (!DSG_SWITCH_ON || !latched_q)) // R12
    else $error("latched discharge switch re-enabled");
  a_latch_chg_off: assert property (lat_chg |=> !CHG_SWITCH_ON) // R21
    else $error("latched charge switch re-enabled");

  c_sc_trip: cover property (sc_run ##1 trip_sc);
  c_sc_cmd_rec: cover property (sc_st_q && rec_sc_cmd ##1 !sc_st_q);
  c_occ_timed_rec: cover property (occ_rec_done ##1 !occ_st_q);
  c_latched: cover property ($rose(latched_q));

endmodule
`default_nettype wire

// *** verification/scocp_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module scocp_host
  import scocp_pkg::*;
(
  input wire logic MCLK,
  output logic [7:0] ADDR,
  output logic [31:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [31:0] RDATA
);
  // ==========================================================
  // Bus idle at time zero
  initial begin
    ADDR = 8'h00;
    WDATA = 32'h0000_0000;
    WR = 1'b0;
    RD = 1'b0;
  end

  // ==========================================================
  // Register cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    WDATA <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // ==========================================================
  // Recovery subcommand with recover bits
  task automatic recover(input logic [1:0] bits);
    wr(OFS_CMD, {14'h0000, bits, SUBCMD_RECOVER});
  endtask
endmodule
`default_nettype wire

// *** verification/tb_short_circuit_overcurrent_protect.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_short_circuit_overcurrent_protect
  import scocp_pkg::*;
;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] sc;
    logic [31:0] charge_overcurrent;
    logic [11:0] pos;
    logic [11:0] neg;
    logic [1:0] al;
  } scocp_row_t;

  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR;
  logic [31:0] WDATA;
  logic WR;
  logic RD;
  logic [31:0] RDATA;
  logic [11:0] SENSE_POS = 12'h000;
  logic [11:0] SENSE_NEG = 12'h000;
  logic CHG_SWITCH_ON;
  logic DSG_SWITCH_ON;
  logic CURRENT_LATCHED;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] s;
  logic [7:0] ra [6] = '{OFS_CTRL, OFS_SC_CFG, OFS_OCC_CFG, OFS_REC_CFG, OFS_STATUS, 8'h20};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
  scocp_row_t rows [11] = '{
    '{32'h63, 32'h0A00, 32'hFF02, 12'd0, 12'd11, 2'b01},
    '{32'h63, 32'h0A00, 32'hFF02, 12'd0, 12'd10, 2'b00},
    '{32'h63, 32'h0A0F, 32'hFF02, 12'd0, 12'd501, 2'b01},
    '{32'h63, 32'h0A0F, 32'hFF02, 12'd0, 12'd500, 2'b00},
    '{32'h63, 32'h0A06, 32'hFF02, 12'd0, 12'd126, 2'b01},
    '{32'h62, 32'h0A00, 32'hFF02, 12'd0, 12'd600, 2'b00},
    '{32'h63, 32'h0A00, 32'hFF02, 12'd4, 12'd0, 2'b10},
    '{32'h63, 32'h0A00, 32'hFF02, 12'd3, 12'd0, 2'b00},
    '{32'h63, 32'h0A00, 32'hFF3E, 12'd124, 12'd0, 2'b10},
    '{32'h63, 32'h0A00, 32'hFF3E, 12'd123, 12'd0, 2'b00},
    '{32'h61, 32'h0A00, 32'hFF3E, 12'd200, 12'd0, 2'b00}};

  scocp_top #(.SEC_US(100), .ALERT_LAG(10)) i_dut (
    .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SENSE_POS(SENSE_POS), .SENSE_NEG(SENSE_NEG), .CHG_SWITCH_ON(CHG_SWITCH_ON),
    .DSG_SWITCH_ON(DSG_SWITCH_ON), .CURRENT_LATCHED(CURRENT_LATCHED));

  scocp_host i_host (.MCLK(MCLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));

  // ==========================================================
  // Clock and timeout
  initial begin
    forever #25 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkr(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask

  task automatic rs(input logic [31:0] exp);
    logic [31:0] d;
    i_host.rd(OFS_STATUS, d);
    chk(d, exp);
  endtask

  task automatic wait_for(input int w, input logic v, input int lim, output int c);
    c = 0;
    #1;
    while (((w == 0) ? CHG_SWITCH_ON : DSG_SWITCH_ON) !== v && c < lim) begin
      @(posedge MCLK);
      #1;
      c++;
    end
    chk(32'(c < lim), 32'h1);
  endtask

  task automatic sense(input logic [11:0] p, input logic [11:0] q);
    @(posedge MCLK);
    SENSE_POS <= p;
    SENSE_NEG <= q;
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge MCLK);
    chk({29'h0, CHG_SWITCH_ON, DSG_SWITCH_ON, CURRENT_LATCHED}, 32'h0);
    RST <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      i_host.rd(ra[i], s);
      chk(s, rv[i]);
    end
    foreach (rows[i]) begin
      i_host.wr(OFS_CTRL, rows[i].ctrl);
      i_host.wr(OFS_SC_CFG, rows[i].sc);
      i_host.wr(OFS_OCC_CFG, rows[i].charge_overcurrent);
      sense(rows[i].pos, rows[i].neg);
      repeat (20) @(posedge MCLK);
      rs({25'h0, 5'h18, rows[i].al});
      sense(12'd0, 12'd0);
      repeat (5) @(posedge MCLK);
    end
    // Timed short circuit trip and recovery
    i_host.wr(OFS_CTRL, 32'h65);
    i_host.wr(OFS_SC_CFG, 32'h0200);
    i_host.wr(OFS_REC_CFG, 32'h0001);
    sense(12'd0, 12'd100);
    repeat (40) @(posedge MCLK);
    rs(32'h61);
    repeat (250) @(posedge MCLK);
    sense(12'd0, 12'd0);
    repeat (3) @(posedge MCLK);
    rs(32'h60);
    sense(12'd0, 12'd100);
    wait_for(1, 1'b0, 800, n);
    chkr(n, 570, 625);
    chk(CHG_SWITCH_ON, 1'b1);
    rs(32'h124);
    sense(12'd0, 12'd0);
    wait_for(1, 1'b1, 4500, n);
    rs(32'h160);
    // Fastest delay, no timed recovery, host recovery
    i_host.wr(OFS_REC_CFG, 32'h0000);
    i_host.wr(OFS_CTRL, 32'h6D);
    i_host.wr(OFS_SC_CFG, 32'h0000);
    sense(12'd0, 12'd100);
    repeat (30) @(posedge MCLK);
    chk(CHG_SWITCH_ON, 1'b0);
    rs(32'h204);
    sense(12'd0, 12'd0);
    repeat (3000) @(posedge MCLK);
    rs(32'h204);
    i_host.wr(OFS_CMD, 32'h0001_009A);
    rs(32'h204);
    i_host.recover(2'b01);
    rs(32'h60);
    // Charge overcurrent trip and host recovery
    i_host.wr(OFS_CTRL, 32'h72);
    i_host.wr(OFS_OCC_CFG, 32'h0002);
    sense(12'd50, 12'd0);
    rs(32'h62);
    wait_for(0, 1'b0, 9400, n);
    chkr(n, 9150, 9225);
    rs(32'h148);
    sense(12'd0, 12'd0);
    repeat (100) @(posedge MCLK);
    rs(32'h148);
    i_host.recover(2'b10);
    rs(32'h60);
    // Charge overcurrent timed recovery
    i_host.wr(OFS_REC_CFG, 32'h0001);
    sense(12'd50, 12'd0);
    wait_for(0, 1'b0, 9400, n);
    sense(12'd0, 12'd0);
    wait_for(0, 1'b1, 4500, n);
    rs(32'h160);
    i_host.recover(2'b00);
    // Latch limit and quiet counter clear
    i_host.wr(OFS_REC_CFG, 32'h0201);
    i_host.wr(OFS_CTRL, 32'h6D);
    for (int k = 0; k < 2; k++) begin
      sense(12'd0, 12'd100);
      repeat (5) @(posedge MCLK);
      sense(12'd0, 12'd0);
      if (k == 0) wait_for(1, 1'b1, 4500, n);
    end
    repeat (4500) @(posedge MCLK);
    chk({CURRENT_LATCHED, CHG_SWITCH_ON, DSG_SWITCH_ON}, 3'b100);
    rs(32'h210);
    repeat (12500) @(posedge MCLK);
    rs(32'h010);
    i_host.recover(2'b01);
    rs(32'h60);
    complete_run();
  end
endmodule
`default_nettype wire
